// ===== hdl/cfms_map.svh
/*
 Register map constants for the filter 8..15 mask source select block.
 Assumes inclusion by bare name from files that need offsets and fields.
*/
`ifndef CFMS_MAP_SVH
`define CFMS_MAP_SVH

`define CFMS_SELECT_OFFSET 4'h0
`define CFMS_SELECT_RESET 16'h0000
`define CFMS_FIELD_WIDTH 2
`define CFMS_FIRST_FILTER 8
`define CFMS_CODE_MASK0 2'h0
`define CFMS_CODE_MASK1 2'h1
`define CFMS_CODE_MASK2 2'h2
`define CFMS_CODE_NONE 2'h3
`define CFMS_RDATA_IDLE 16'h0000
`define CFMS_SEL_ALL_ON 8'hff
`define CFMS_SEL_ALL_OFF 8'h00

`endif

// ===== hdl/cfms_pkg.sv
/*
 Types for the filter 8..15 mask source select block.
 Assumes cfms_map.svh is on the include path.
*/
`default_nettype none
`include "cfms_map.svh"

package cfms_pkg;
   typedef enum logic [1:0] {
      CFMS_SRC_MASK0 = `CFMS_CODE_MASK0,
      CFMS_SRC_MASK1 = `CFMS_CODE_MASK1,
      CFMS_SRC_MASK2 = `CFMS_CODE_MASK2,
      CFMS_SRC_NONE = `CFMS_CODE_NONE
   } cfms_src_t;

   typedef struct packed {
      logic [15:0] filter_hi_mask_source_select;
      logic [15:0] rd_data;
      logic [7:0] use_mask0;
      logic [7:0] use_mask1;
      logic [7:0] use_mask2;
      logic [7:0] use_no_mask;
   } cfms_state_t;
endpackage

`default_nettype wire

// ===== hdl/cfms_decode.sv
/*
 Decodes one 2-bit mask source field into per-mask one-hot selects.
 Assumes the field is the register's incoming value, ahead of the register; purely combinational.
*/
`default_nettype none
`include "cfms_map.svh"

module cfms_decode
   import cfms_pkg::*;
(
   // Field in
   input wire logic [1:0] field,
   // Selects out
   output logic use_mask0,
   output logic use_mask1,
   output logic use_mask2,
   output logic use_no_mask
);
   always_comb begin
      use_mask0 = 1'b0;
      use_mask1 = 1'b0;
      use_mask2 = 1'b0;
      use_no_mask = 1'b0;
      unique case (cfms_src_t'(field))
         CFMS_SRC_MASK2: use_mask2 = 1'b1;
         CFMS_SRC_MASK1: use_mask1 = 1'b1;
         CFMS_SRC_MASK0: use_mask0 = 1'b1;
         CFMS_SRC_NONE: use_no_mask = 1'b1;
      endcase
   end
endmodule

`default_nettype wire

// ===== hdl/cfms_select.sv
/*
 Mask source select register for acceptance filters 8..15.
 Assumes a single-cycle strobe register port on clk and synchronous reset.
*/
`default_nettype none
`include "cfms_map.svh"

// Operation
// - Eight 2-bit fields, filter 15 at bits 15:14 down to filter 8 at 1:0.
// - Code 10 selects mask register set two.
// - Code 01 selects set one; code 00 selects set zero.
// - Code 11 applies no mask; all identifier bits compared.
module cfms_select
   import cfms_pkg::*;
#(
   parameter int NUM_FILTERS = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Per-filter mask source, index 0 is filter 8
   output logic [2*NUM_FILTERS-1:0] filter_mask_source,
   // Per-filter one-hot selects
   output logic [NUM_FILTERS-1:0] filter_use_mask0,
   output logic [NUM_FILTERS-1:0] filter_use_mask1,
   output logic [NUM_FILTERS-1:0] filter_use_mask2,
   output logic [NUM_FILTERS-1:0] filter_use_no_mask
);
   // Register word holds exactly eight two-bit fields
   if (NUM_FILTERS != 8) begin : g_bad_count
      $error("cfms_select serves exactly eight filters");
   end

   // Reset image: register clear, so every filter starts on mask set zero
   localparam cfms_state_t RESET_STATE = '{
      filter_hi_mask_source_select: `CFMS_SELECT_RESET,
      rd_data: `CFMS_RDATA_IDLE,
      use_mask0: `CFMS_SEL_ALL_ON,
      use_mask1: `CFMS_SEL_ALL_OFF,
      use_mask2: `CFMS_SEL_ALL_OFF,
      use_no_mask: `CFMS_SEL_ALL_OFF
   };

   cfms_state_t state;
   cfms_state_t next_state;
   logic write_hit;
   logic read_hit;
   logic [15:0] sel_value;
   logic [NUM_FILTERS-1:0] dec0;
   logic [NUM_FILTERS-1:0] dec1;
   logic [NUM_FILTERS-1:0] dec2;
   logic [NUM_FILTERS-1:0] decn;

   // Strobe aimed at the select register
   function automatic logic hits_select(input logic strobe, input logic [3:0] addr);
      return strobe && (addr == `CFMS_SELECT_OFFSET);
   endfunction

   // One filter's field out of the packed register word
   function automatic logic [1:0] field_of(input logic [15:0] word, input int idx);
      return word[`CFMS_FIELD_WIDTH*idx +: `CFMS_FIELD_WIDTH];
   endfunction

   assign write_hit = hits_select(reg_wr, reg_addr);
   assign read_hit = hits_select(reg_rd, reg_addr);

   // Value the register takes at the coming edge
   assign sel_value = write_hit ? reg_wdata : state.filter_hi_mask_source_select;

   // Field i sits at bits 2i+1:2i; filter 8 lowest, filter 15 highest
   genvar i;
   generate
      for (i = 0; i < NUM_FILTERS; i++) begin : g_flt
         cfms_decode u_dec (
            .field(field_of(sel_value, i)),
            .use_mask0(dec0[i]),
            .use_mask1(dec1[i]),
            .use_mask2(dec2[i]),
            .use_no_mask(decn[i])
         );
      end
   endgenerate

   // Selects decoded from the incoming value, so they change with the register
   always_comb begin
      next_state = state;
      next_state.filter_hi_mask_source_select = sel_value;
      next_state.rd_data = `CFMS_RDATA_IDLE;
      if (read_hit) begin
         next_state.rd_data = state.filter_hi_mask_source_select;
      end
      next_state.use_mask0 = dec0;
      next_state.use_mask1 = dec1;
      next_state.use_mask2 = dec2;
      next_state.use_no_mask = decn;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= RESET_STATE;
      end else begin
         state <= next_state;
      end
   end

   // Every output straight from the state register
   assign reg_rdata = state.rd_data;
   assign filter_mask_source = state.filter_hi_mask_source_select;
   assign filter_use_mask0 = state.use_mask0;
   assign filter_use_mask1 = state.use_mask1;
   assign filter_use_mask2 = state.use_mask2;
   assign filter_use_no_mask = state.use_no_mask;
endmodule

`default_nettype wire

// ===== verif/cfms_chk.sv
/*
 Port checker for the mask source select register.
 Assumes binding onto cfms_select and cfms_map.svh on the include path.
*/
`default_nettype none
`include "cfms_map.svh"
module cfms_chk #(
   parameter int NUM_FILTERS = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   // Filter side
   input wire logic [2*NUM_FILTERS-1:0] filter_mask_source,
   input wire logic [NUM_FILTERS-1:0] filter_use_mask0,
   input wire logic [NUM_FILTERS-1:0] filter_use_mask1,
   input wire logic [NUM_FILTERS-1:0] filter_use_mask2,
   input wire logic [NUM_FILTERS-1:0] filter_use_no_mask
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [NUM_FILTERS-1:0] hi;
   logic [NUM_FILTERS-1:0] lo;
   always_comb begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
         {hi[i], lo[i]} = filter_mask_source[2*i +: 2];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wr;
      reg_wr && reg_addr == `CFMS_SELECT_OFFSET;
   endsequence
   sequence s_rd;
      reg_rd && reg_addr == `CFMS_SELECT_OFFSET;
   endsequence
   a_write_lands: assert property (s_wr |=> filter_mask_source == $past(reg_wdata))
      else $error("write lost");
   a_code_zero: assert property (filter_use_mask0 == (~hi & ~lo))
      else $error("mask zero select wrong");
   a_read_idle: assert property (!(reg_rd && reg_addr == `CFMS_SELECT_OFFSET)
      |=> reg_rdata == 16'h0000) else $error("read data not idle");
   a_code_none: assert property (filter_use_no_mask == (hi & lo))
      else $error("no-mask select wrong");
   a_code_two: assert property (filter_use_mask2 == (hi & ~lo))
      else $error("mask two select wrong");
   a_code_one: assert property (filter_use_mask1 == (~hi & lo))
      else $error("mask one select wrong");
   a_read_back: assert property (s_rd |=> reg_rdata == $past(filter_mask_source))
      else $error("read data wrong");
endmodule
bind cfms_select cfms_chk #(.NUM_FILTERS(NUM_FILTERS)) chk (
   .clk(clk),
   .rst(rst),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata),
   .filter_mask_source(filter_mask_source),
   .filter_use_mask0(filter_use_mask0),
   .filter_use_mask1(filter_use_mask1),
   .filter_use_mask2(filter_use_mask2),
   .filter_use_no_mask(filter_use_no_mask)
);
`default_nettype wire

// ===== verif/cfms_flt_model.sv
/* Filter comparator side: turns the one-hot selects back into codes.
 Assumes eight filters; a select that is not one-hot yields unknown. */
`default_nettype none
module cfms_flt_model (
   // One-hot selects from the block
   input wire logic [7:0] use0,
   input wire logic [7:0] use1,
   input wire logic [7:0] use2,
   input wire logic [7:0] usen,
   // Code each comparator applies
   output logic [15:0] applied
);
   timeunit 1ns;
   timeprecision 1ns;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         applied[2*i+:2] = {usen[i] | use2[i], usen[i] | use1[i]};
         if ($countones({use0[i], use1[i], use2[i], usen[i]}) != 1) applied[2*i+:2] = 2'bxx;
      end
   end
endmodule
`default_nettype wire

// ===== verif/tb.sv
/* Random and corner writes, read-back, unmapped access and reset.
 Assumes cfms_select with eight filters at offset 0x0. */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, wr = 0, rd = 0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0, rdata, fms, applied;
   logic [7:0] u0, u1, u2, un;
   int errors = 0, n_compared = 0;
   always #5 clk = ~clk;
   cfms_select dut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
      .reg_rd(rd), .reg_rdata(rdata), .filter_mask_source(fms), .filter_use_mask0(u0),
      .filter_use_mask1(u1), .filter_use_mask2(u2), .filter_use_no_mask(un));
   cfms_flt_model far (.use0(u0), .use1(u1), .use2(u2), .usen(un), .applied(applied));
   function automatic logic [7:0] sel_of(input logic [15:0] cfg, input logic [1:0] code);
      for (int f = 0; f < 8; f++) begin
         sel_of[f] = (cfg[2*f +: 2] == code);
      end
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] cfg);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata, exp);
      check(applied, cfg);
      check(fms, cfg);
      check({u1, u0}, {sel_of(cfg, 2'h1), sel_of(cfg, 2'h0)});
      check({un, u2}, {sel_of(cfg, 2'h3), sel_of(cfg, 2'h2)});
      @(posedge clk);
   endtask
   task automatic wrap_up;
      $display("errors=%0d compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      logic [15:0] w;
      void'($urandom(22));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd_reg(4'h0, 16'h0, 16'h0);
      for (int k = 0; k < 12; k++) begin
         w = k < 4 ? {8{k[1:0]}} : (k == 4 ? 16'he4e4 : 16'($urandom));
         wr_reg(4'h0, w);
         rd_reg(4'h0, w, w);
         wr_reg(4'h5, ~w);
         rd_reg(4'h5, 16'h0, w);
      end
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd_reg(4'h0, 16'h0, 16'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
